// ---- mrr_pkg.sv ----
// package for the move/return/rotate execution slice
// assumes a 14-bit instruction word and a 13-bit program counter
package mrr_pkg;
    localparam int INSTR_W = 14;
    localparam int PC_W = 13;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    // instruction encodings
    localparam logic [13:0] IDLE_OP_CODE = 14'h0000;
    localparam logic [13:0] INT_RETURN_CODE = 14'h0009;
    localparam logic [6:0] MOVE_FILE_TOP = 7'h08; // low six bits give bits 13:8 = 001000
    localparam logic [6:0] STORE_ACC_TOP = 7'h01; // bits 13:7 = 0000001
    localparam logic [5:0] ROTATE_LEFT_TOP = 6'h0d; // bits 13:8
    localparam logic [3:0] LOAD_LIT_TOP = 4'h3; // bits 13:8 = 1100xx
    localparam logic [3:0] LIT_RETURN_TOP = 4'h3; // bits 13:8 = 1101xx
    localparam logic [1:0] LOAD_LIT_SUB = 2'h0;
    localparam logic [1:0] LIT_RETURN_SUB = 2'h1;
    // reset values
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [12:0] PC_RESET = 13'h0000;
    // status bit positions in the flag vector {zero, digit carry, carry}
    localparam int CARRY_BIT = 0;
    localparam int ZERO_BIT = 2;
    typedef enum logic [2:0] {
        MRR_IDLE, MRR_MOVE_FILE, MRR_LOAD_LIT, MRR_INT_RETURN,
        MRR_STORE_ACC, MRR_LIT_RETURN, MRR_ROTATE_LEFT, MRR_OTHER
    } mrr_op_t;
    typedef enum {
        MRR_EXEC, MRR_FLUSH
    } mrr_state_t;
endpackage

// ---- mrr_core.sv ----
// execution slice for move, literal, return, rotate and idle instructions
// assumes instructions arrive one per cycle from fetch and file reads are combinational
`timescale 1ns/1ps
module mrr_core (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // instruction from fetch
    input wire logic instr_valid,
    input wire logic [mrr_pkg::INSTR_W-1:0] instr,
    // file register read port
    input wire logic [mrr_pkg::DATA_W-1:0] file_rdata,
    // stack and flags from the rest of the core
    input wire logic [mrr_pkg::PC_W-1:0] top_of_stack,
    input wire logic [2:0] status_in,
    // file register write port and write address
    output logic [mrr_pkg::FADDR_W-1:0] file_addr,
    output logic file_we,
    output logic [mrr_pkg::DATA_W-1:0] file_wdata,
    // core state
    output logic [mrr_pkg::DATA_W-1:0] acc,
    output logic [mrr_pkg::PC_W-1:0] pc,
    output logic [2:0] status_out,
    output logic status_we,
    output logic global_interrupt_enable,
    output logic stack_pop,
    output logic flush
);
    import mrr_pkg::*;

    // decoding is shared by execute and assertions
    function automatic mrr_op_t decode(input logic [13:0] w);
        if (w == IDLE_OP_CODE)
            return MRR_IDLE;
        else if (w == INT_RETURN_CODE)
            return MRR_INT_RETURN;
        else if (w[13:8] == MOVE_FILE_TOP[5:0])
            return MRR_MOVE_FILE;
        else if (w[13:7] == STORE_ACC_TOP)
            return MRR_STORE_ACC;
        else if (w[13:8] == ROTATE_LEFT_TOP)
            return MRR_ROTATE_LEFT;
        else if (w[13:12] == LOAD_LIT_TOP[1:0] && w[11:10] == LOAD_LIT_SUB)
            return MRR_LOAD_LIT;
        else if (w[13:12] == LIT_RETURN_TOP[1:0] && w[11:10] == LIT_RETURN_SUB)
            return MRR_LIT_RETURN;
        else
            return MRR_OTHER;
    endfunction

    mrr_op_t op;
    mrr_state_t state;
    logic dest_file;
    logic [7:0] rot_result;
    logic go;

    // address of the instruction in hand; registered below so it lines up with file_we
    logic [FADDR_W-1:0] next_file_addr;

    assign op = decode(instr);
    assign dest_file = instr[7];
    assign go = instr_valid && state == MRR_EXEC;
    // old carry enters bit 0, old bit 7 leaves as carry
    assign rot_result = {file_rdata[6:0], status_in[CARRY_BIT]};
    assign next_file_addr = instr[6:0];

    // flush state: a literal or interrupt return spends one dead cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= MRR_EXEC;
            flush <= 1'b0;
        end else begin
            case (state)
                MRR_EXEC: begin
                    if (go && (op == MRR_LIT_RETURN || op == MRR_INT_RETURN)) begin
                        state <= MRR_FLUSH;
                        flush <= 1'b1;
                    end else begin
                        flush <= 1'b0;
                    end
                end
                MRR_FLUSH: begin
                    state <= MRR_EXEC;
                    flush <= 1'b0;
                end
                default: begin
                    state <= MRR_EXEC;
                    flush <= 1'b0;
                end
            endcase
        end
    end

    // working register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            acc <= ACC_RESET;
        end else if (go) begin
            case (op)
                MRR_MOVE_FILE: if (!dest_file) acc <= file_rdata;
                MRR_LOAD_LIT: acc <= instr[7:0];
                MRR_LIT_RETURN: acc <= instr[7:0];
                MRR_ROTATE_LEFT: if (!dest_file) acc <= rot_result;
                default: acc <= acc;
            endcase
        end
    end

    // file register writes, registered so outputs come from flops
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            file_we <= 1'b0;
            file_wdata <= ACC_RESET;
            file_addr <= '0;
        end else begin
            file_addr <= next_file_addr;
            file_we <= 1'b0;
            if (go) begin
                case (op)
                    MRR_MOVE_FILE: begin
                        file_we <= dest_file;
                        file_wdata <= file_rdata;
                    end
                    MRR_STORE_ACC: begin
                        file_we <= 1'b1;
                        file_wdata <= acc;
                    end
                    MRR_ROTATE_LEFT: begin
                        file_we <= dest_file;
                        file_wdata <= rot_result;
                    end
                    default: file_we <= 1'b0;
                endcase
            end
        end
    end

    // status flags: only the move touches zero, only the rotate touches carry
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            status_out <= 3'h0;
            status_we <= 1'b0;
        end else begin
            status_out <= status_in;
            status_we <= 1'b0;
            if (go) begin
                case (op)
                    MRR_MOVE_FILE: begin
                        status_out[ZERO_BIT] <= (file_rdata == 8'h00);
                        status_we <= 1'b1;
                    end
                    MRR_ROTATE_LEFT: begin
                        status_out[CARRY_BIT] <= file_rdata[7];
                        status_we <= 1'b1;
                    end
                    default: status_we <= 1'b0;
                endcase
            end
        end
    end

    // program counter, stack pop and global interrupt enable
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pc <= PC_RESET;
            stack_pop <= 1'b0;
            global_interrupt_enable <= 1'b0;
        end else begin
            stack_pop <= 1'b0;
            if (go) begin
                case (op)
                    MRR_INT_RETURN: begin
                        pc <= top_of_stack;
                        stack_pop <= 1'b1;
                        global_interrupt_enable <= 1'b1;
                    end
                    MRR_LIT_RETURN: begin
                        pc <= top_of_stack;
                        stack_pop <= 1'b1;
                    end
                    default: pc <= pc + 13'h0001;
                endcase
            end
        end
    end

    // assertions
    sequence s_lit_ret_issue;
        go && op == MRR_LIT_RETURN;
    endsequence

    a_move_to_acc: assert property (@(posedge sys_clk) disable iff (!rst_n)
        go && op == MRR_MOVE_FILE && !dest_file |=> acc == $past(file_rdata))
        else $error("move to working register lost value");
    a_move_to_file: assert property (@(posedge sys_clk) disable iff (!rst_n)
        go && op == MRR_MOVE_FILE && dest_file |=> file_we && acc == $past(acc))
        else $error("move to file did not write back");
    a_move_zero_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
        go && op == MRR_MOVE_FILE |=> status_out[ZERO_BIT] == ($past(file_rdata) == 8'h00)
            && status_out[CARRY_BIT] == $past(status_in[CARRY_BIT]))
        else $error("zero flag wrong after move");
    a_load_literal: assert property (@(posedge sys_clk) disable iff (!rst_n)
        go && op == MRR_LOAD_LIT |=> acc == $past(instr[7:0]) && !status_we)
        else $error("literal load wrong");
    a_int_return: assert property (@(posedge sys_clk) disable iff (!rst_n)
        go && op == MRR_INT_RETURN |=> pc == $past(top_of_stack) && global_interrupt_enable)
        else $error("interrupt return wrong");
    a_store_acc: assert property (@(posedge sys_clk) disable iff (!rst_n)
        go && op == MRR_STORE_ACC |=> file_we && file_wdata == $past(acc) && !status_we)
        else $error("store of working register wrong");
    a_lit_return: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_lit_ret_issue |=> acc == $past(instr[7:0]) && pc == $past(top_of_stack))
        else $error("literal return wrong");
    a_lit_ret_flush: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_lit_ret_issue |=> flush ##1 !flush)
        else $error("literal return flush cycle missing");
    a_rotate_carry: assert property (@(posedge sys_clk) disable iff (!rst_n)
        go && op == MRR_ROTATE_LEFT |=> status_out[CARRY_BIT] == $past(file_rdata[7])
            && status_out[ZERO_BIT] == $past(status_in[ZERO_BIT]))
        else $error("rotate carry wrong");
    a_rotate_dest: assert property (@(posedge sys_clk) disable iff (!rst_n)
        go && op == MRR_ROTATE_LEFT && dest_file |=> file_we
            && file_wdata == {$past(file_rdata[6:0]), $past(status_in[CARRY_BIT])})
        else $error("rotate result not written to file");
    a_idle_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
        go && op == MRR_IDLE |=> pc == $past(pc) + 13'h0001 && !file_we && !status_we)
        else $error("idle changed state");
    a_flags_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
        go && (op == MRR_INT_RETURN || op == MRR_LIT_RETURN) |=> !status_we)
        else $error("return changed flags");
endmodule // mrr_core

// ---- tb_mrr_core.sv ----
// self-checking bench for the move/return/rotate execution slice
// assumes mrr_pkg is compiled first; the design carries its own assertions
`timescale 1ns/1ps
module tb_mrr_core;
    import mrr_pkg::*;
    typedef struct packed {
        logic [13:0] ins;
        logic [7:0] rd;
        logic [2:0] si;
        logic ld;
        logic [7:0] av;
        logic we;
        logic [7:0] wd;
        logic swe;
        logic [2:0] so;
        logic ret;
    } mrr_tb_row_t;
    logic sys_clk, rst_n, instr_valid, file_we, status_we;
    logic global_interrupt_enable, stack_pop, flush, exp_int_en;
    logic [13:0] instr;
    logic [7:0] file_rdata, file_wdata, acc, exp_acc;
    logic [12:0] top_of_stack, pc, exp_pc, ret_addr;
    logic [2:0] status_in, status_out;
    logic [6:0] file_addr;
    int bad_count, checks_done;
    // ins, rdata, flags in, acc load, acc, we, wdata, flag we, flags out, return
    mrr_tb_row_t rows [13] = '{
        '{14'h3300, 8'h5a, 3'h7, 1'b1, 8'h00, 1'b0, 8'h00, 1'b0, 3'h0, 1'b0},
        '{14'h30ff, 8'h5a, 3'h7, 1'b1, 8'hff, 1'b0, 8'h00, 1'b0, 3'h0, 1'b0},
        '{14'h087f, 8'h00, 3'h3, 1'b1, 8'h00, 1'b0, 8'h00, 1'b1, 3'h7, 1'b0},
        '{14'h0800, 8'ha5, 3'h7, 1'b1, 8'ha5, 1'b0, 8'h00, 1'b1, 3'h3, 1'b0},
        '{14'h08d5, 8'h00, 3'h0, 1'b0, 8'h00, 1'b1, 8'h00, 1'b1, 3'h4, 1'b0},
        '{14'h00ff, 8'h33, 3'h5, 1'b0, 8'h00, 1'b1, 8'ha5, 1'b0, 3'h0, 1'b0},
        '{14'h0d12, 8'h81, 3'h6, 1'b1, 8'h02, 1'b0, 8'h00, 1'b1, 3'h7, 1'b0},
        '{14'h0dff, 8'h40, 3'h1, 1'b0, 8'h00, 1'b1, 8'h81, 1'b1, 3'h0, 1'b0},
        '{14'h0000, 8'h77, 3'h5, 1'b0, 8'h00, 1'b0, 8'h00, 1'b0, 3'h0, 1'b0},
        '{14'h0064, 8'h77, 3'h2, 1'b0, 8'h00, 1'b0, 8'h00, 1'b0, 3'h0, 1'b0},
        '{14'h343c, 8'h11, 3'h7, 1'b1, 8'h3c, 1'b0, 8'h00, 1'b0, 3'h0, 1'b1},
        '{14'h0009, 8'h22, 3'h1, 1'b0, 8'h00, 1'b0, 8'h00, 1'b0, 3'h0, 1'b1},
        '{14'h37c3, 8'h33, 3'h4, 1'b1, 8'hc3, 1'b0, 8'h00, 1'b0, 3'h0, 1'b1}
    };

    mrr_core i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
        .file_rdata(file_rdata), .top_of_stack(top_of_stack), .status_in(status_in),
        .file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata), .acc(acc),
        .pc(pc), .status_out(status_out), .status_we(status_we),
        .global_interrupt_enable(global_interrupt_enable), .stack_pop(stack_pop),
        .flush(flush)
    );

    // 50 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // one compare for every result, all widened to the pc width
    task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // pulses stand one cycle, so this runs right after the capturing edge
    task automatic chk_row(input mrr_tb_row_t r);
        chk(13'(acc), 13'(exp_acc), "acc");
        chk(pc, exp_pc, "pc");
        chk(13'(file_we), 13'(r.we), "file_we");
        if (r.we) begin
            chk(13'(file_wdata), 13'(r.wd), "wdata");
            chk(13'(file_addr), 13'(r.ins[6:0]), "addr");
        end
        chk(13'(status_we), 13'(r.swe), "status_we");
        if (r.swe) begin
            chk(13'(status_out), 13'(r.so), "flags");
        end
        chk(13'(stack_pop), 13'(r.ret), "pop");
        chk(13'(flush), 13'(r.ret), "flush");
        chk(13'(global_interrupt_enable), 13'(exp_int_en), "int enable");
    endtask

    task automatic chk_zero();
        chk(13'(acc), 13'h0000, "acc rst");
        chk(pc, 13'h0000, "pc rst");
        chk(13'({file_we, status_we, global_interrupt_enable, stack_pop, flush}), 13'h0000,
            "pulses rst");
    endtask

    task automatic final_report();
        $display("mismatches %0d, comparisons %0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // watchdog, run needs well under a hundred cycles
    initial begin
        repeat (2000) @(posedge sys_clk);
        bad_count++;
        final_report();
    end

    initial begin
        rst_n = 1'b0;
        instr_valid = 1'b0;
        instr = 14'h0000;
        file_rdata = 8'h00;
        top_of_stack = 13'h0000;
        status_in = 3'h0;
        bad_count = 0;
        checks_done = 0;
        exp_pc = 13'h0000;
        exp_acc = 8'h00;
        exp_int_en = 1'b0;
        repeat (10) @(posedge sys_clk);
        #1 chk_zero();
        @(posedge sys_clk);
        rst_n <= 1'b1;
        // table rows, each taken alone; a gap cycle covers the dead cycle of returns
        for (int i = 0; i < 13; i++) begin
            @(posedge sys_clk);
            ret_addr = 13'h1a00 | 13'(i);
            instr <= rows[i].ins;
            file_rdata <= rows[i].rd;
            status_in <= rows[i].si;
            top_of_stack <= ret_addr;
            instr_valid <= 1'b1;
            @(posedge sys_clk);
            instr_valid <= 1'b0;
            exp_pc = rows[i].ret ? ret_addr : exp_pc + 13'h0001;
            if (rows[i].ld) exp_acc = rows[i].av;
            if (rows[i].ins == INT_RETURN_CODE) exp_int_en = 1'b1;
            #1 chk_row(rows[i]);
        end
        // literal return followed at once by a load offered in the dead cycle
        @(posedge sys_clk);
        instr <= 14'h3411;
        top_of_stack <= 13'h0abc;
        instr_valid <= 1'b1;
        @(posedge sys_clk);
        instr <= 14'h3022;
        #1 chk(13'(flush), 13'h0001, "flush b2b");
        @(posedge sys_clk);
        #1 chk(13'(acc), 13'h0011, "acc in dead cycle");
        chk(13'({flush, stack_pop}), 13'h0000, "pulses end");
        chk(pc, 13'h0abc, "pc after return");
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        #1 chk(13'(acc), 13'h0022, "load after dead cycle");
        chk(pc, 13'h0abd, "pc after load");
        // reset in mid-run clears the sticky enable too
        @(posedge sys_clk);
        rst_n <= 1'b0;
        @(posedge sys_clk);
        rst_n <= 1'b1;
        #1 chk_zero();
        final_report();
    end
endmodule // tb_mrr_core
